/* hdl/rws_pkg.sv */
// Shared constants and types for the reset and watchdog supervisor.
package rws_pkg;

   // Clock rate and release delay timing.
   localparam int CLK_HZ = 10_000_000;
   localparam int RELEASE_DELAY_MS = 2;
   localparam int RELEASE_DELAY_CYCLES = (RELEASE_DELAY_MS * CLK_HZ) / 1000;

   // Shortest watchdog period in instruction cycles (16K); code 111 gives 2048K.
   localparam int WDT_BASE_CYCLES = 16384;
   localparam int WDT_CNT_W = 22;

   // Register byte offsets on the bus.
   localparam logic [7:0] POWER_CTRL_OFS = 8'h00;
   localparam logic [7:0] SUPV_CTRL_OFS = 8'h04;
   localparam logic [7:0] SERVICE_OFS = 8'h08;
   localparam logic [7:0] WDT_COUNT_OFS = 8'h0c;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
   localparam logic [7:0] IRQ_CLEAR_OFS = 8'h14;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h18;

   // Field positions in the supervisor control register.
   localparam int SC_ENABLE_BIT = 0;
   localparam int SC_SOFT_RESTART_BIT = 1;
   localparam int SC_LOCKED_BIT = 2;
   localparam int SC_IDLE_FREEZE_BIT = 4;
   localparam int SC_PERIOD_LSB = 5;

   // Field positions in the power control and interrupt registers.
   localparam int PC_COLD_START_BIT = 0;
   localparam int IRQ_COLD_BIT = 0;
   localparam int IRQ_LOW_SUPPLY_BIT = 1;
   localparam int IRQ_WDT_BIT = 2;
   localparam int IRQ_W = 3;

   // Values after reset.
   localparam logic [7:0] SUPV_CTRL_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // Locked-mode service sequence.
   localparam logic [7:0] SERVICE_FIRST = 8'h1e;
   localparam logic [7:0] SERVICE_SECOND = 8'he1;

   // AHB transfer encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // Progress through the locked-mode service sequence.
   typedef enum logic [0:0] {
      seq_wait = 1'b0,
      seq_armed = 1'b1
   } rws_seq_type;

endpackage

/* hdl/rws_delay_if.sv */
// Link between the supervisor and one release delay counter.
`timescale 1ns/1ps
interface rws_delay_if;
   logic hold;
   logic busy;
   modport ctrl (output hold, input busy);
   modport dly (input hold, output busy);
endinterface

/* hdl/rws_release_delay.sv */
// Release delay counter that stretches the end of a supply-low indication.
`timescale 1ns/1ps
module rws_release_delay #(
   parameter int CYCLES = rws_pkg::RELEASE_DELAY_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   rws_delay_if.dly port
);

   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   generate
      if (CYCLES < 1) begin : g_bad
         $error("Release delay must be at least one cycle.");
      end
   endgenerate

   logic [CW-1:0] cnt_reg;
   logic busy_reg;

   // Busy from reset, restarts on every hold, and falls after the full count.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || port.hold) begin
         cnt_reg <= '0;
         busy_reg <= 1'b1;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg + CW'(1);
         busy_reg <= (cnt_reg != LAST);
      end
   end

   assign port.busy = busy_reg;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_hold_busy: assert property (port.hold |=> busy_reg) // [RULE_01]
      else $error("Delay not busy after hold.");
   a_release_count: assert property ($fell(busy_reg) |-> // [RULE_05]
      $past(cnt_reg) == LAST && !$past(port.hold))
      else $error("Delay released before full count.");

endmodule // rws_release_delay

/* hdl/rws_supervisor_top.sv */
// Reset supervisor and instruction-cycle watchdog with an AHB-Lite register slave.
//
// Notes on behaviour
// [RULE_01] Reset is held while power-on supply-low is seen and for 2 ms after it clears.
// [RULE_02] A returning power-on supply-low indication reasserts reset at once.
// [RULE_03] Every power-on reset sets the cold-start flag in the power control register.
// [RULE_04] The low-supply detector asserts reset immediately when it trips.
// [RULE_05] After the low-supply detector clears its own counter holds reset about 2 ms.
// [RULE_06] The watchdog advances once per cycle with a period of 16K to 2048K cycles.
// [RULE_07] Each step of the three-bit period code doubles the timeout.
// [RULE_08] A power-on reset leaves the watchdog disabled.
// [RULE_09] The watchdog does not count in power-down mode.
// [RULE_10] A watchdog timeout without service pulses an internal reset to the core.
// [RULE_11] In software mode the soft restart bit restarts the count and self-clears.
// [RULE_12] In locked mode writing 1e then e1 starts or services the watchdog.
// [RULE_13] With idle freeze set the watchdog holds its count while idle.
// [RULE_14] In software mode the enable bit freezes the count; in locked mode it shows run.
// [RULE_15] All reset requests and release delays merge into one internal reset.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module rws_supervisor_top #(
   parameter int RELEASE_CYCLES = rws_pkg::RELEASE_DELAY_CYCLES,
   parameter int WDT_BASE = rws_pkg::WDT_BASE_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic supply_low_pin,
   input wire logic low_supply_detector,
   input wire logic idle_mode,
   input wire logic power_down_mode,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic core_reset,
   output logic wdt_reset_pulse,
   output logic irq
);

   localparam int CW = rws_pkg::WDT_CNT_W;
   localparam logic [CW-1:0] BASE_W = CW'(WDT_BASE);

   generate
      if (WDT_BASE < 2 || longint'(WDT_BASE) * 128 >= (longint'(1) << CW)) begin : g_bad
         $error("Watchdog base period does not fit the counter.");
      end
   endgenerate

   // Timeout length for a period code; doubles with each step of the code.
   function automatic logic [CW-1:0] wdt_limit(input logic [2:0] ps);
      wdt_limit = BASE_W << ps; // [RULE_07]
   endfunction

   // Synchronisers for the two detector pins.
   logic por_s1_reg, por_s2_reg, por_d_reg;
   logic bod_s1_reg, bod_s2_reg, bod_d_reg;

   // Detector levels come from analog comparators, so two flops precede any use.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         por_s1_reg <= 1'b0;
         por_s2_reg <= 1'b0;
         por_d_reg <= 1'b0;
         bod_s1_reg <= 1'b0;
         bod_s2_reg <= 1'b0;
         bod_d_reg <= 1'b0;
      end else begin
         por_s1_reg <= supply_low_pin;
         por_s2_reg <= por_s1_reg;
         por_d_reg <= por_s2_reg;
         bod_s1_reg <= low_supply_detector;
         bod_s2_reg <= bod_s1_reg;
         bod_d_reg <= bod_s2_reg;
      end
   end

   wire por_rise = por_s2_reg && !por_d_reg;
   wire bod_rise = bod_s2_reg && !bod_d_reg;

   // Release delay counters, one per detector.
   rws_delay_if por_if ();
   rws_delay_if bod_if ();

   // Each detector has its own counter so one cannot shorten the other's delay.
   assign por_if.hold = por_s2_reg; // [RULE_01]
   assign bod_if.hold = bod_s2_reg; // [RULE_05]

   rws_release_delay #(.CYCLES(RELEASE_CYCLES)) u_por_delay (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .port(por_if.dly)
   );

   rws_release_delay #(.CYCLES(RELEASE_CYCLES)) u_bod_delay (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .port(bod_if.dly)
   );

   // Register bus slave with zero wait states.
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;

   wire take = hsel && hready && htrans == rws_pkg::HTRANS_NONSEQ
      && hsize == rws_pkg::HSIZE_WORD;
   wire [7:0] a_ofs = {haddr[7:2], 2'b00};
   wire wr_power = wr_pend_reg && wr_addr_reg == rws_pkg::POWER_CTRL_OFS;
   wire wr_ctrl = wr_pend_reg && wr_addr_reg == rws_pkg::SUPV_CTRL_OFS;
   wire wr_service = wr_pend_reg && wr_addr_reg == rws_pkg::SERVICE_OFS;
   wire wr_irq_clr = wr_pend_reg && wr_addr_reg == rws_pkg::IRQ_CLEAR_OFS;
   wire wr_irq_en = wr_pend_reg && wr_addr_reg == rws_pkg::IRQ_ENABLE_OFS;

   // The slave never stalls and always answers OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;

   // Supervisor and watchdog state.
   logic cold_flag_reg;
   logic en_reg, soft_reg, locked_reg, idle_frz_reg;
   logic [2:0] ps_reg;
   logic locked_run_reg;
   logic [CW-1:0] wdt_cnt_reg;
   logic wdt_pulse_reg;
   logic core_reset_reg;
   logic [rws_pkg::IRQ_W-1:0] irq_stat_reg, irq_en_reg;
   rws_pkg::rws_seq_type seq_reg, seq_next;

   // Any reset request or pending release keeps the core in reset.
   wire reset_any = por_s2_reg || bod_s2_reg || por_if.busy || bod_if.busy
      || wdt_pulse_reg; // [RULE_15]

   // In locked mode the enable bit shows whether the watchdog runs.
   wire en_view = locked_reg ? locked_run_reg : en_reg; // [RULE_14]
   wire running = en_view;
   wire count_ok = running && !power_down_mode // [RULE_09]
      && !(idle_mode && idle_frz_reg); // [RULE_13]
   wire soft_restart = soft_reg && !locked_reg; // [RULE_11]
   wire seq_fire = wr_service && seq_reg == rws_pkg::seq_armed
      && hwdata[7:0] == rws_pkg::SERVICE_SECOND && locked_reg; // [RULE_12]
   wire wdt_restart = soft_restart || seq_fire;
   wire [CW-1:0] limit = wdt_limit(ps_reg); // [RULE_06]
   wire timeout = count_ok && !wdt_restart && wdt_cnt_reg == limit - CW'(1);

   wire [7:0] ctrl_view = {ps_reg, idle_frz_reg, 1'b0, locked_reg, soft_reg, en_view};
   wire [rws_pkg::IRQ_W-1:0] irq_events = {timeout, bod_rise, por_rise};

   // Read data is chosen in the address phase so it stands through the data phase.
   wire [31:0] rd_mux =
      (a_ofs == rws_pkg::POWER_CTRL_OFS) ? {31'h0, cold_flag_reg} :
      (a_ofs == rws_pkg::SUPV_CTRL_OFS) ? {24'h0, ctrl_view} :
      (a_ofs == rws_pkg::WDT_COUNT_OFS) ? {10'h0, wdt_cnt_reg} :
      (a_ofs == rws_pkg::IRQ_STATUS_OFS) ? {29'h0, irq_stat_reg} :
      (a_ofs == rws_pkg::IRQ_ENABLE_OFS) ? {29'h0, irq_en_reg} : 32'h0;

   // Bus phase tracking; a write lands at the end of its data phase.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rdata_reg <= 32'h0;
      end else begin
         wr_pend_reg <= take && hwrite;
         wr_addr_reg <= a_ofs;
         rdata_reg <= (take && !hwrite) ? rd_mux : 32'h0;
      end
   end

   // Service sequence: 1e arms, e1 while armed fires, anything else disarms.
   always_comb begin
      seq_next = seq_reg;
      if (wr_service) begin
         if (hwdata[7:0] == rws_pkg::SERVICE_FIRST) begin
            seq_next = rws_pkg::seq_armed;
         end else begin
            seq_next = rws_pkg::seq_wait;
         end
      end
   end

   // Sequence state is dropped on any internal reset, so half a key never survives it.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || core_reset_reg) begin
         seq_reg <= rws_pkg::seq_wait;
      end else begin
         seq_reg <= seq_next; // [RULE_12]
      end
   end

   // Cold-start flag: set while power-on reset is seen; software writes zero to clear.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cold_flag_reg <= 1'b1;
      end else if (por_s2_reg) begin
         cold_flag_reg <= 1'b1; // [RULE_03]
      end else if (wr_power) begin
         cold_flag_reg <= hwdata[rws_pkg::PC_COLD_START_BIT];
      end
   end

   // Control bits return to their reset values during any internal reset,
   // which is the only way out of locked mode once it runs.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || core_reset_reg) begin
         {ps_reg, idle_frz_reg} <= rws_pkg::SUPV_CTRL_RST[7:4];
         locked_reg <= rws_pkg::SUPV_CTRL_RST[rws_pkg::SC_LOCKED_BIT];
         en_reg <= rws_pkg::SUPV_CTRL_RST[rws_pkg::SC_ENABLE_BIT]; // [RULE_08]
         soft_reg <= rws_pkg::SUPV_CTRL_RST[rws_pkg::SC_SOFT_RESTART_BIT];
      end else begin
         if (wr_ctrl) begin
            ps_reg <= hwdata[rws_pkg::SC_PERIOD_LSB +: 3];
            idle_frz_reg <= hwdata[rws_pkg::SC_IDLE_FREEZE_BIT];
         end
         // Mode may not change while the locked watchdog runs.
         if (wr_ctrl && !locked_run_reg) begin
            locked_reg <= hwdata[rws_pkg::SC_LOCKED_BIT];
         end
         // Enable is read-only while locked mode is selected.
         if (wr_ctrl && !locked_reg) begin
            en_reg <= hwdata[rws_pkg::SC_ENABLE_BIT]; // [RULE_14]
         end
         // A new write of one wins over the self-clear of the previous one.
         if (wr_ctrl && hwdata[rws_pkg::SC_SOFT_RESTART_BIT]) begin
            soft_reg <= 1'b1;
         end else if (soft_restart) begin
            soft_reg <= 1'b0; // [RULE_11]
         end else if (wr_ctrl) begin
            soft_reg <= 1'b0;
         end
      end
   end

   // Locked run flag: set by the service sequence, cleared only by reset.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || core_reset_reg) begin
         locked_run_reg <= 1'b0; // [RULE_08]
      end else if (seq_fire) begin
         locked_run_reg <= 1'b1; // [RULE_12]
      end
   end

   // Watchdog counter; a disabled count is frozen, not cleared.
   always_ff @(posedge clk_sys) begin
      if (!rst_n || core_reset_reg) begin
         wdt_cnt_reg <= '0;
         wdt_pulse_reg <= 1'b0;
      end else begin
         wdt_pulse_reg <= timeout; // [RULE_10]
         if (wdt_restart || timeout) begin
            wdt_cnt_reg <= '0;
         end else if (count_ok) begin
            wdt_cnt_reg <= wdt_cnt_reg + CW'(1); // [RULE_06]
         end
      end
   end

   // Internal reset is registered so the core never sees a decode glitch.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         core_reset_reg <= 1'b1;
      end else begin
         core_reset_reg <= reset_any; // [RULE_02] [RULE_04] [RULE_15]
      end
   end

   assign core_reset = core_reset_reg;
   assign wdt_reset_pulse = wdt_pulse_reg;

   // Interrupt status: events set, write-one clears, and a set wins the tie.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq_stat_reg <= rws_pkg::IRQ_RST;
         irq_en_reg <= rws_pkg::IRQ_RST;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~(wr_irq_clr ? hwdata[2:0] : 3'h0)) | irq_events;
         if (wr_irq_en) begin
            irq_en_reg <= hwdata[2:0];
         end
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // Checks on the supervisor behaviour.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_por_holds_reset: assert property (por_s2_reg |=> core_reset) // [RULE_01]
      else $error("Reset not held during power-on low supply.");
   a_por_reassert: assert property ($rose(por_s2_reg) |=> core_reset) // [RULE_02]
      else $error("Power-on reset not reasserted at once.");
   a_cold_flag_set: assert property (por_s2_reg |=> cold_flag_reg) // [RULE_03]
      else $error("Cold-start flag not set by power-on reset.");
   a_bod_immediate: assert property ($rose(bod_s2_reg) |=> core_reset) // [RULE_04]
      else $error("Low-supply reset not immediate.");
   a_bod_release: assert property ($fell(bod_s2_reg) && !por_s2_reg |=> // [RULE_05]
      core_reset [*2])
      else $error("Low-supply release not delayed.");
   a_wdt_period: assert property (wdt_pulse_reg |-> // [RULE_06]
      $past(wdt_cnt_reg) == wdt_limit($past(ps_reg)) - CW'(1))
      else $error("Watchdog fired at wrong count.");
   a_wdt_doubling: assert property (wdt_pulse_reg |-> // [RULE_07]
      (($past(wdt_cnt_reg) + CW'(1)) >> $past(ps_reg)) == BASE_W)
      else $error("Period code does not double the timeout.");
   a_por_disables: assert property (por_s2_reg |=> ##1 !en_view) // [RULE_08]
      else $error("Watchdog enabled after power-on reset.");
   a_wdt_frozen: assert property (!count_ok && !wdt_restart && !core_reset_reg // [RULE_09]
      |=> $stable(wdt_cnt_reg))
      else $error("Watchdog counted while frozen.");
   a_powerdown_hold: assert property (power_down_mode && !wdt_restart // [RULE_09]
      && !core_reset_reg |=> $stable(wdt_cnt_reg))
      else $error("Watchdog counted in power-down mode.");
   a_timeout_reset: assert property (timeout |=> wdt_reset_pulse ##1 core_reset) // [RULE_10]
      else $error("Timeout did not reset the core.");
   a_soft_selfclear: assert property (soft_restart && !wr_ctrl |=> // [RULE_11]
      !soft_reg && wdt_cnt_reg == '0)
      else $error("Soft restart bit did not self-clear.");
   a_locked_start: assert property (seq_fire && !core_reset_reg |=> // [RULE_12]
      locked_run_reg && wdt_cnt_reg == '0)
      else $error("Service sequence did not start watchdog.");
   a_locked_sticky: assert property (locked_run_reg && !core_reset_reg |=> // [RULE_12]
      locked_run_reg)
      else $error("Locked watchdog stopped without reset.");
   a_idle_freeze: assert property (idle_mode && idle_frz_reg && !wdt_restart // [RULE_13]
      && !core_reset_reg |=> $stable(wdt_cnt_reg))
      else $error("Watchdog counted in idle with freeze set.");
   a_enable_view: assert property (locked_reg |-> ctrl_view[0] == locked_run_reg) // [RULE_14]
      else $error("Enable bit does not show locked run state.");
   a_reset_merge: assert property (!reset_any |=> !core_reset) // [RULE_15]
      else $error("Core reset held with no request.");

   // Main scenarios that the bench is expected to reach.
   c_cold_release: cover property ($fell(core_reset) && cold_flag_reg);
   c_powerdown_freeze: cover property (power_down_mode && en_view);
   c_wdt_timeout: cover property (wdt_reset_pulse);
   c_locked_start: cover property (seq_fire);

endmodule // rws_supervisor_top

/* test/rws_core.sv */
// Core-side bus master model that services and configures the supervisor.
`timescale 1ns/1ps
module rws_core (
   input wire logic clk_sys,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // The bus idles from time zero so nothing is taken while reset is held.
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = rws_pkg::HSIZE_WORD;
      hwdata = 32'h0;
   end

   // One single word transfer; the stale write data is inverted so it never looks valid.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd_q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= rws_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      hsize <= rws_pkg::HSIZE_WORD;
      hwdata <= ~hwdata;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd_q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] q;
      xfer(1'b1, a, wd, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask

   // Locked-mode service: the two key bytes back to back.
   task automatic service();
      wr(rws_pkg::SERVICE_OFS, {24'h0, rws_pkg::SERVICE_FIRST});
      wr(rws_pkg::SERVICE_OFS, {24'h0, rws_pkg::SERVICE_SECOND});
   endtask
endmodule // rws_core

/* test/rws_supervisor_top_tb.sv */
// Self-checking bench for the reset and watchdog supervisor.
`timescale 1ns/1ps
module rws_supervisor_top_tb;
   // Short counts keep the run brief; every expectation derives from these.
   localparam int RC = 8;
   localparam int WB = 4;
   localparam logic [7:0] SC = rws_pkg::SUPV_CTRL_OFS;
   localparam logic [7:0] CNT = rws_pkg::WDT_COUNT_OFS;
   localparam logic [7:0] PC = rws_pkg::POWER_CTRL_OFS;
   localparam logic [7:0] IEN = rws_pkg::IRQ_ENABLE_OFS;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic supply_low_pin = 1'b0;
   logic low_supply_detector = 1'b0;
   logic idle_mode = 1'b0;
   logic power_down_mode = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, core_reset, wdt_reset_pulse, irq;
   logic [31:0] haddr, hwdata, hrdata, q, d;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int n_mismatch = 0;
   int compares = 0;
   int n;
   // Rows: register offset and the value it must read after reset.
   logic [7:0] ra [0:4] = '{PC, SC, CNT, IEN, 8'h1c};
   logic [31:0] re [0:4] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

   // Free-running system clock.
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end

   rws_supervisor_top #(.RELEASE_CYCLES(RC), .WDT_BASE(WB)) u_rws_supervisor_top (
      .clk_sys(clk_sys), .rst_n(rst_n), .supply_low_pin(supply_low_pin),
      .low_supply_detector(low_supply_detector), .idle_mode(idle_mode),
      .power_down_mode(power_down_mode), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_reset(core_reset),
      .wdt_reset_pulse(wdt_reset_pulse), .irq(irq));

   rws_core u_rws_core (
      .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // Cycles until the core reset drops, bounded so a stuck reset shows up.
   task automatic rel(output int k);
      k = 0;
      while (core_reset !== 1'b0 && k < 200) begin
         @(posedge clk_sys);
         k++;
      end
   endtask

   // Cycles until the watchdog pulse appears.
   task automatic pw(output int k);
      k = 0;
      while (wdt_reset_pulse !== 1'b1 && k < 2000) begin
         @(posedge clk_sys);
         k++;
      end
   endtask

   // Count advance over a fixed window; q keeps the later reading.
   task automatic dlt(output logic [31:0] dd);
      logic [31:0] a;
      u_rws_core.rd(CNT, a);
      cyc(20);
      u_rws_core.rd(CNT, q);
      dd = q - a;
   endtask

   task automatic stop_test();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog on the bench itself: the whole sequence needs a few thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      stop_test();
   end

   initial begin
      cyc(8);
      chk(32'(core_reset), 32'h1, "reset held");
      rst_n <= 1'b1;
      rel(n);
      chk(32'(n >= RC), 32'h1, "release delay after reset");
      chk(32'(hresp), 32'h0, "bus response");
      for (int i = 0; i < 5; i++) begin
         u_rws_core.rd(ra[i], q);
         chk(q, re[i], "register after reset");
      end
      // Every period code: timeout length, reset to core, control cleared afterwards.
      for (int ps = 0; ps < 8; ps++) begin
         u_rws_core.wr(SC, 32'((ps << 5) | 1));
         pw(n);
         chk(32'(n >= (WB << ps) && n <= (WB << ps) + 3), 32'h1, "period");
         @(posedge clk_sys);
         chk(32'(core_reset), 32'h1, "watchdog reset");
         rel(n);
         u_rws_core.rd(SC, q);
         chk(q, 32'h0, "control after warm reset");
      end
      u_rws_core.rd(rws_pkg::IRQ_STATUS_OFS, q);
      chk(q & 32'h4, 32'h4, "timeout event");
      u_rws_core.wr(SC, 32'he1);
      dlt(d);
      chk(32'(d != 0), 32'h1, "counting");
      u_rws_core.wr(SC, 32'he0);
      dlt(d);
      chk(32'(d == 0 && q != 0), 32'h1, "frozen not cleared");
      power_down_mode <= 1'b1;
      u_rws_core.wr(SC, 32'he1);
      dlt(d);
      chk(d, 32'h0, "power down");
      power_down_mode <= 1'b0;
      idle_mode <= 1'b1;
      u_rws_core.wr(SC, 32'hf1);
      dlt(d);
      chk(d, 32'h0, "idle frozen");
      u_rws_core.wr(SC, 32'he1);
      dlt(d);
      chk(32'(d != 0), 32'h1, "idle counting");
      idle_mode <= 1'b0;
      u_rws_core.wr(SC, 32'he3);
      u_rws_core.rd(SC, q);
      chk(q & 32'h2, 32'h0, "restart bit self clears");
      u_rws_core.rd(CNT, q);
      chk(32'(q < 12), 32'h1, "count restarted");
      // Locked mode: start by key, no stopping, restart bit inert, service, timeout.
      u_rws_core.wr(SC, 32'he4);
      u_rws_core.wr(rws_pkg::SERVICE_OFS, {24'h0, rws_pkg::SERVICE_FIRST});
      u_rws_core.wr(rws_pkg::SERVICE_OFS, 32'h0);
      u_rws_core.wr(rws_pkg::SERVICE_OFS, {24'h0, rws_pkg::SERVICE_SECOND});
      u_rws_core.rd(SC, q);
      chk(q & 32'h1, 32'h0, "broken key refused");
      u_rws_core.service();
      u_rws_core.rd(SC, q);
      chk(q & 32'h5, 32'h5, "locked running");
      u_rws_core.wr(SC, 32'he0);
      u_rws_core.rd(SC, q);
      chk(q & 32'h5, 32'h5, "stop refused");
      dlt(d);
      chk(32'(d != 0), 32'h1, "still counting");
      u_rws_core.wr(SC, 32'he6);
      u_rws_core.rd(SC, q);
      chk(q & 32'h2, 32'h2, "restart bit stays");
      u_rws_core.service();
      u_rws_core.rd(CNT, q);
      chk(32'(q < 12), 32'h1, "serviced");
      pw(n);
      chk(32'(n <= (WB << 7) + 3), 32'h1, "locked timeout");
      rel(n);
      u_rws_core.rd(SC, q);
      chk(q, 32'h0, "lock left by reset");
      // Power-on detector with a return during the release delay.
      u_rws_core.wr(PC, 32'h0);
      u_rws_core.rd(PC, q);
      chk(q, 32'h0, "cold flag cleared");
      u_rws_core.wr(IEN, 32'h2);
      supply_low_pin <= 1'b1;
      cyc(4);
      chk(32'(core_reset), 32'h1, "power-on reset");
      supply_low_pin <= 1'b0;
      cyc(4);
      supply_low_pin <= 1'b1;
      cyc(4);
      supply_low_pin <= 1'b0;
      rel(n);
      chk(32'(n >= RC && n <= RC + 6), 32'h1, "power-on delay");
      u_rws_core.rd(PC, q);
      chk(q, 32'h1, "cold flag set");
      chk(32'(irq), 32'h0, "masked interrupt");
      // Low-supply detector: immediate reset, own delay, interrupt set and cleared.
      low_supply_detector <= 1'b1;
      cyc(4);
      chk(32'(core_reset), 32'h1, "low supply reset");
      low_supply_detector <= 1'b0;
      rel(n);
      chk(32'(n >= RC && n <= RC + 6), 32'h1, "low supply delay");
      chk(32'(irq), 32'h1, "interrupt raised");
      u_rws_core.wr(rws_pkg::IRQ_CLEAR_OFS, 32'h7);
      cyc(1);
      chk(32'(irq), 32'h0, "interrupt cleared");
      u_rws_core.wr(IEN, 32'h1);
      low_supply_detector <= 1'b1;
      cyc(4);
      low_supply_detector <= 1'b0;
      rel(n);
      chk(32'(irq), 32'h0, "interrupt masked");
      u_rws_core.rd(rws_pkg::IRQ_STATUS_OFS, q);
      chk(q, 32'h2, "status kept");
      stop_test();
   end
endmodule // rws_supervisor_top_tb
